// file: hw/filt_path.sv
// programmable filter path: hp x2, lp, five-band eq, adc init, path select
// assumes one-cycle sample strobes from the adc and serial-in domains
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module filt_path
   import filt_path_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // sample sources
   input  wire sample_s     adcIn,
   input  wire sample_s     serIn,
   // sample sinks
   output sample_s          serOut,
   output sample_s          dacOut
);
   ////////////////////////////////////////////////////////////////////
   // register file
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [31:0] hpCoef_r, hpCoef_nxt, lpCoef_r, lpCoef_nxt;
   logic [15:0] eqA_r [NUM_BANDS];
   logic [15:0] eqB_r [NUM_BANDS];
   logic [15:0] eqC_r [NUM_BANDS];
   logic [31:0] prdata_nxt;
   logic        pready_nxt, pslverr_nxt;
   logic        initBusy_r, initBusy_nxt;
   logic [10:0] initCnt_r, initCnt_nxt;
   logic        adcPwrd_r, adcPwrd_nxt;
   logic        wrEn, rdEn;

   // address decode shared by read and write
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == OFS_CTRL) || (a == OFS_HPCOEF) ||
                 (a == OFS_LPCOEF) || (a == OFS_STAT) ||
                 (a >= OFS_EQBASE &&
                  a < 8'(OFS_EQBASE + 8'(NUM_BANDS * 8)) && a[1:0] == 2'b00);
   endfunction

   assign wrEn = psel && penable && pwrite && !pready;
   assign rdEn = psel && penable && !pwrite && !pready;

   // one wait state: answer registered, pready high on second access cycle
   always_comb
   begin
      ctrl_nxt    = ctrl_r;
      hpCoef_nxt  = hpCoef_r;
      lpCoef_nxt  = lpCoef_r;
      prdata_nxt  = prdata;
      pready_nxt  = psel && penable && !pready;
      pslverr_nxt = psel && penable && !pready && !isMapped(paddr);
      if (wrEn && paddr == OFS_CTRL)
         ctrl_nxt = {18'h0, pwdata[13:0]};
      // coefficient writes trusted to follow idle-state use
      if (wrEn && paddr == OFS_HPCOEF)
         hpCoef_nxt = {2'h0, pwdata[29:16], 2'h0, pwdata[13:0]};
      if (wrEn && paddr == OFS_LPCOEF)
         lpCoef_nxt = {2'h0, pwdata[29:16], 2'h0, pwdata[13:0]};
      if (rdEn)
      begin
         prdata_nxt = 32'h0;
         unique case (1'b1)
            paddr == OFS_CTRL:   prdata_nxt = ctrl_r;
            paddr == OFS_HPCOEF: prdata_nxt = hpCoef_r;
            paddr == OFS_LPCOEF: prdata_nxt = lpCoef_r;
            paddr == OFS_STAT:   prdata_nxt = {20'h0, initCnt_r, initBusy_r};
            default:
            begin
               if (isMapped(paddr))
               begin
                  // word 0: a | b<<16, word 1: c
                  if (paddr[2])
                     prdata_nxt = {16'h0, eqC_r[3'(paddr[7:3] - 5'd2)]};
                  else
                     prdata_nxt = {eqB_r[3'(paddr[7:3] - 5'd2)],
                                   eqA_r[3'(paddr[7:3] - 5'd2)]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         ctrl_r   <= CTRL_RST;
         hpCoef_r <= 32'h0;
         lpCoef_r <= 32'h0;
         prdata   <= 32'h0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end
      else
      begin
         ctrl_r   <= ctrl_nxt;
         hpCoef_r <= hpCoef_nxt;
         lpCoef_r <= lpCoef_nxt;
         prdata   <= prdata_nxt;
         pready   <= pready_nxt;
         pslverr  <= pslverr_nxt;
      end
   end

   // equalizer coefficient words, one pair of words per band
   for (genvar n = 0; n < NUM_BANDS; n++)
   begin : g_eqreg
      logic hitAb, hitC;
      assign hitAb = wrEn && paddr == 8'(OFS_EQBASE + 8'(n * 8));
      assign hitC  = wrEn && paddr == 8'(OFS_EQBASE + 8'(n * 8 + 4));
      always_ff @(posedge ref_clk)
      begin
         if (!rst_b)
         begin
            eqA_r[n] <= 16'h0;
            eqB_r[n] <= 16'h0;
            eqC_r[n] <= 16'h0;
         end
         else
         begin
            if (hitAb)
               eqA_r[n] <= pwdata[15:0];
            if (hitAb)
               eqB_r[n] <= pwdata[31:16];
            if (hitC)
               eqC_r[n] <= pwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // adc initialization counter, counts recorded samples
   logic adcPwr;
   assign adcPwr = ctrl_r[BIT_ADCPWR];

   always_comb
   begin
      adcPwrd_nxt  = adcPwr;
      initBusy_nxt = initBusy_r;
      initCnt_nxt  = initCnt_r;
      if (adcPwr && !adcPwrd_r)
      begin
         // rising power bit restarts init
         initBusy_nxt = 1'b1;
         initCnt_nxt  = ctrl_r[BIT_SHORT] ? INIT_SHORT : INIT_LONG;
      end
      else if (!adcPwr)
      begin
         initBusy_nxt = 1'b0;
         initCnt_nxt  = 11'd0;
      end
      else if (initBusy_r && adcIn.valid)
      begin
         initCnt_nxt  = initCnt_r - 11'd1;
         initBusy_nxt = (initCnt_r != 11'd1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         adcPwrd_r  <= 1'b0;
         initBusy_r <= 1'b0;
         initCnt_r  <= 11'd0;
      end
      else
      begin
         adcPwrd_r  <= adcPwrd_nxt;
         initBusy_r <= initBusy_nxt;
         initCnt_r  <= initCnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // filter chain: source select then hp, hp, lp, eq
   logic               recPath, toDac, toSdo, step;
   logic signed [31:0] src, hp1Y, hp2Y, lpY, stg1, stg2, stg3;
   logic signed [31:0] bandY [NUM_BANDS];
   logic signed [31:0] eqSum, recZeroed;
   logic signed [13:0] hpA, hpB, lpA, lpB;

   assign recPath = ctrl_r[BIT_LVL];
   assign toDac   = ctrl_r[BIT_TODAC];
   assign toSdo   = ctrl_r[BIT_TOSDO];
   assign hpA     = hpCoef_r[13:0];
   assign hpB     = hpCoef_r[29:16];
   assign lpA     = lpCoef_r[13:0];
   assign lpB     = lpCoef_r[29:16];

   // record side feeds the filter when level control sits on record path
   // for zero forcing during init
   assign recZeroed = initBusy_r ? 32'sd0 : 32'(adcIn.data);
   assign src  = recPath ? recZeroed : 32'(serIn.data);
   assign step = (recPath ? adcIn.valid : serIn.valid)
                 && ctrl_r[BIT_FPWR];

   // hp stage: y = a*x - a*x1 + b*y1, coefs signed 2^13
   iir_section #(.CW(CW_SHORT)) u_hp1 (
      .ref_clk(ref_clk), .rst_b(rst_b), .step(step), .xIn(src),
      .b0(hpA), .b1(-hpA), .b2(14'sh0), .a1(hpB), .a2(14'sh0),
      .yOut(hp1Y));
   assign stg1 = ctrl_r[BIT_HP1EN] ? hp1Y : src;

   iir_section #(.CW(CW_SHORT)) u_hp2 (
      .ref_clk(ref_clk), .rst_b(rst_b), .step(step), .xIn(stg1),
      .b0(hpA), .b1(-hpA), .b2(14'sh0), .a1(hpB), .a2(14'sh0),
      .yOut(hp2Y));
   assign stg2 = ctrl_r[BIT_HP2EN] ? hp2Y : stg1;

   // lp stage: y = a*x + a*x1 - b*y1
   iir_section #(.CW(CW_SHORT)) u_lp (
      .ref_clk(ref_clk), .rst_b(rst_b), .step(step), .xIn(stg2),
      .b0(lpA), .b1(lpA), .b2(14'sh0), .a1(-lpB), .a2(14'sh0),
      .yOut(lpY));
   assign stg3 = ctrl_r[BIT_LPEN] ? lpY : stg2;

   // band: y = a*x - a*x2 + b*y1 + c*y2
   for (genvar n = 0; n < NUM_BANDS; n++)
   begin : g_band
      iir_section #(.CW(CW_EQ)) u_band (
         .ref_clk(ref_clk), .rst_b(rst_b), .step(step), .xIn(stg3),
         .b0(eqA_r[n]), .b1(16'sh0), .b2(-eqA_r[n]),
         .a1(eqB_r[n]), .a2(eqC_r[n]), .yOut(bandY[n]));
   end

   // disabled bands add nothing
   always_comb
   begin
      eqSum = stg3;
      for (int n = 0; n < NUM_BANDS; n++)
         if (ctrl_r[BIT_EQEN + n])
            eqSum = eqSum + bandY[n];
   end

   // saturate to the 16-bit sample range
   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767)
         sat16 = 16'sh7FFF;
      else if (v < -32'sd32768)
         sat16 = 16'sh8000;
      else
         sat16 = v[15:0];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // output routing, registered
   sample_s serOut_nxt, dacOut_nxt;
   logic    bypassDac;
   assign bypassDac = !toDac || !ctrl_r[BIT_FPWR];

   always_comb
   begin
      serOut_nxt.valid = 1'b0;
      serOut_nxt.data  = serOut.data;
      dacOut_nxt.valid = 1'b0;
      dacOut_nxt.data  = dacOut.data;
      // serial out: filtered or raw recording, zero during init
      if (toSdo && step)
      begin
         serOut_nxt.valid = 1'b1;
         serOut_nxt.data  = initBusy_r ? 16'sh0 : sat16(eqSum);
      end
      else if (!toSdo && adcIn.valid)
      begin
         serOut_nxt.valid = 1'b1;
         serOut_nxt.data  = 16'(recZeroed);
      end
      // dac: playback never waits on init
      if (!bypassDac && step)
      begin
         dacOut_nxt.valid = 1'b1;
         dacOut_nxt.data  = sat16(eqSum);
      end
      else if (bypassDac && serIn.valid)
      begin
         dacOut_nxt.valid = 1'b1;
         dacOut_nxt.data  = serIn.data;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         serOut <= '0;
         dacOut <= '0;
      end
      else
      begin
         serOut <= serOut_nxt;
         dacOut <= dacOut_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   property p_init_start;
      @(posedge ref_clk) disable iff (!rst_b)
      (adcPwr && !adcPwrd_r) |=> initBusy_r;
   endproperty
   a_init_start: assert property (p_init_start)
      else $error("init did not start on power rise");

   property p_init_zero;
      @(posedge ref_clk) disable iff (!rst_b)
      (initBusy_r && adcIn.valid && !toSdo) |=> serOut.data == 16'sh0;
   endproperty
   a_init_zero: assert property (p_init_zero)
      else $error("nonzero record sample during init");

   property p_init_len;
      @(posedge ref_clk) disable iff (!rst_b)
      (adcPwr && !adcPwrd_r) |=>
         (initCnt_r == (ctrl_r[BIT_SHORT] ? INIT_SHORT : INIT_LONG));
   endproperty
   a_init_len: assert property (p_init_len)
      else $error("wrong init length loaded");

   property p_dac_pass;
      @(posedge ref_clk) disable iff (!rst_b)
      (bypassDac && serIn.valid) |=> dacOut.valid && $past(serIn.data)
         == dacOut.data;
   endproperty
   a_dac_pass: assert property (p_dac_pass)
      else $error("playback not passed to dac");

   property p_sdo_path;
      @(posedge ref_clk) disable iff (!rst_b)
      (toSdo && step) |=> serOut.valid;
   endproperty
   a_sdo_path: assert property (p_sdo_path)
      else $error("filter output missing on serial out");

   property p_hp_bypass;
      @(posedge ref_clk) disable iff (!rst_b)
      (step && toDac && ctrl_r[BIT_HP1EN +: 3] == 3'b000 &&
       ctrl_r[BIT_EQEN +: NUM_BANDS] == '0)
         |=> dacOut.data == $past(src[15:0]);
   endproperty
   a_hp_bypass: assert property (p_hp_bypass)
      else $error("hp stage not unity when off");

   property p_lp_bypass;
      @(posedge ref_clk) disable iff (!rst_b)
      !ctrl_r[BIT_LPEN] |-> stg3 == stg2;
   endproperty
   a_lp_bypass: assert property (p_lp_bypass)
      else $error("lp stage not unity when off");

   property p_eq_off;
      @(posedge ref_clk) disable iff (!rst_b)
      (ctrl_r[BIT_EQEN +: NUM_BANDS] == '0) |-> eqSum == stg3;
   endproperty
   a_eq_off: assert property (p_eq_off)
      else $error("eq adds output with all bands off");

   property p_one_step;
      @(posedge ref_clk) disable iff (!rst_b)
      step |=> (serOut.valid || dacOut.valid || !(toSdo || toDac));
   endproperty
   a_one_step: assert property (p_one_step)
      else $error("sample not produced for step");

   c_init: cover property (@(posedge ref_clk) initBusy_r ##1 !initBusy_r);
   c_rec:  cover property (@(posedge ref_clk) toSdo && step);
   c_play: cover property (@(posedge ref_clk) toDac && step);
endmodule

// file: hw/filt_path_pkg.sv
// package for the programmable filter path: register map, fields, timing
// assumes a 32-bit apb slave and 16-bit two's-complement samples
package filt_path_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_HPCOEF = 8'h04;
   localparam logic [7:0] OFS_LPCOEF = 8'h08;
   localparam logic [7:0] OFS_STAT   = 8'h0C;
   localparam logic [7:0] OFS_EQBASE = 8'h10;
   localparam int         NUM_BANDS  = 5;
   localparam int         CW_SHORT   = 14;
   localparam int         CW_EQ      = 16;
   localparam int         FRAC_BITS  = 13;
   // control bit positions
   localparam int BIT_ADCPWR = 0;
   localparam int BIT_SHORT  = 1;
   localparam int BIT_LVL    = 2;
   localparam int BIT_TODAC  = 3;
   localparam int BIT_TOSDO  = 4;
   localparam int BIT_FPWR   = 5;
   localparam int BIT_HP1EN  = 6;
   localparam int BIT_HP2EN  = 7;
   localparam int BIT_LPEN   = 8;
   localparam int BIT_EQEN   = 9;
   localparam logic [31:0] CTRL_RST = 32'h0000_0014;
   // init cycle lengths in sample periods
   localparam logic [10:0] INIT_LONG  = 11'd1059;
   localparam logic [10:0] INIT_SHORT = 11'd291;
   typedef struct packed {
      logic               valid;
      logic signed [15:0] data;
   } sample_s;
endpackage

// file: hw/iir_section.sv
// one sample of a generic biquad with coefficient scale 2^13
// assumes coefficients stable while enabled; state updates on step only
`timescale 1ns/1ps
module iir_section
   import filt_path_pkg::*;
#(
   parameter int CW = 16
)(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst_b,
   // sample step
   input  wire logic                 step,
   input  wire logic signed [31:0]   xIn,
   // coefficients b0 b1 b2 a1 a2 (y = b*x + a1*y1 + a2*y2)
   input  wire logic signed [CW-1:0] b0,
   input  wire logic signed [CW-1:0] b1,
   input  wire logic signed [CW-1:0] b2,
   input  wire logic signed [CW-1:0] a1,
   input  wire logic signed [CW-1:0] a2,
   // filtered value, combinational from xIn and state
   output logic signed [31:0]        yOut
);
   logic signed [31:0] x1_r, x2_r, y1_r, y2_r;
   logic signed [31:0] x1_nxt, x2_nxt, y1_nxt, y2_nxt;
   logic signed [63:0] acc;

   // direct form one; wide accumulator keeps headroom before the shift
   always_comb
   begin
      acc = 64'(b0 * xIn) + 64'(b1 * x1_r) + 64'(b2 * x2_r)
          + 64'(a1 * y1_r) + 64'(a2 * y2_r);
      yOut = 32'(acc >>> FRAC_BITS);
      x1_nxt = step ? xIn  : x1_r;
      x2_nxt = step ? x1_r : x2_r;
      y1_nxt = step ? yOut : y1_r;
      y2_nxt = step ? y1_r : y2_r;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         x1_r <= '0;
         x2_r <= '0;
         y1_r <= '0;
         y2_r <= '0;
      end
      else
      begin
         x1_r <= x1_nxt;
         x2_r <= x2_nxt;
         y1_r <= y1_nxt;
         y2_r <= y2_nxt;
      end
   end
endmodule

// file: verif/audio_far_end.sv
// far-end model: decimator and serial input port feeding the filter path
// assumes the bench calls send from one thread, one sample per frame
`timescale 1ns/1ps
module audio_far_end
   import filt_path_pkg::*;
(
   // clock
   input  wire logic ref_clk,
   // sample lines toward the path
   output sample_s   adcIn,
   output sample_s   serIn
);

   // idle lines at time zero
   initial
   begin
      adcIn = '0;
      serIn = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // one word per frame, strobe for a single clock; afterwards the data
   // line shows the inverse so a stale copy can never look valid
   task automatic send(input logic fromAdc, input logic [15:0] x);
      @(posedge ref_clk);
      if (fromAdc)
         adcIn <= {1'b1, x};
      else
         serIn <= {1'b1, x};
      @(posedge ref_clk);
      if (fromAdc)
         adcIn <= {1'b0, ~x};
      else
         serIn <= {1'b0, ~x};
   endtask

endmodule

// file: verif/filt_path_test.sv
// self-checking bench for the filter path: apb set-up, init, filters
// assumes a single-clock apb slave and one output pulse per input sample
`timescale 1ns/1ps
module filt_path_test
   import filt_path_pkg::*;
();

   // coefficient 0.5 scaled by 2^13 in the a field, b left at zero
   localparam logic [31:0] HALFCOEF = 32'h0000_1000;
   localparam logic [15:0] SMP      = 16'h03E8;
   localparam logic [15:0] HALF     = 16'h01F4;
   localparam logic [15:0] QTR      = 16'h00FA;
   localparam logic [15:0] NQTR     = 16'hFF06;
   localparam logic [15:0] ONEH     = 16'h05DC;

   logic        ref_clk;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   sample_s     adcIn;
   sample_s     serIn;
   sample_s     serOut;
   sample_s     dacOut;
   int          fail_count = 0;
   int          n_checks   = 0;
   int          cycles     = 0;
   logic [31:0] rdVal;
   logic        rdErr;
   logic [15:0] yVal;

   filt_path filt_path_inst (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .adcIn   (adcIn),
      .serIn   (serIn),
      .serOut  (serOut),
      .dacOut  (dacOut)
   );

   audio_far_end audio_far_end_inst (
      .ref_clk (ref_clk),
      .adcIn   (adcIn),
      .serIn   (serIn)
   );

   ////////////////////////////////////////////////////////////////////////
   // free-running clock, never gated while blocks are powered
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // hang guard: longest run is the 1059-sample init, well under this
   always @(posedge ref_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 30000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge ref_clk);
      penable <= 1'b1;
      // only the hang guard ends a wait that never sees pready
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      rdVal = prdata;
      rdErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      apb(1'b1, addr, data);
   endtask

   task automatic rd(input logic [7:0] addr);
      apb(1'b0, addr, 32'h0000_0000);
   endtask

   // send one sample, catch the pulse on the chosen output, compare
   task automatic xfer(input logic fromAdc, input logic toDac,
                       input logic [15:0] x, input logic [15:0] exp);
      int   n;
      logic got;
      audio_far_end_inst.send(fromAdc, x);
      got  = 1'b0;
      yVal = ~exp; // a missing pulse can never pass for a match
      for (n = 0; n < 4 && !got; n++)
      begin
         #1;
         got = ((toDac ? dacOut.valid : serOut.valid) === 1'b1);
         if (got)
            yVal = toDac ? dacOut.data : serOut.data;
         else
            @(posedge ref_clk);
      end
      chk(toDac ? "dacOut" : "serOut", {16'h0000, exp}, {16'h0000, yVal});
   endtask

   // enable a setting, flush old state with zeros, then three steps
   task automatic run3(input logic [31:0] ctrl, input logic [15:0] e0,
                       input logic [15:0] e1, input logic [15:0] e2);
      wr(OFS_CTRL, ctrl);
      repeat (2) audio_far_end_inst.send(1'b0, 16'h0000);
      repeat (3) @(posedge ref_clk);
      xfer(1'b0, 1'b1, SMP, e0);
      xfer(1'b0, 1'b1, SMP, e1);
      xfer(1'b0, 1'b1, SMP, e2);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      int m;
      int n;
      int len;
      rst_b   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      // reset map and an unmapped place
      rd(OFS_CTRL);
      chk("ctrl", 32'h0000_0014, rdVal);
      rd(OFS_STAT);
      chk("stat", 32'h0000_0000, rdVal);
      chk("pslverrOk", 32'h0000_0000, {31'h0, rdErr});
      rd(8'h40);
      chk("pslverr", 32'h0000_0001, {31'h0, rdErr});
      chk("unmapped", 32'h0000_0000, rdVal);
      // short then long init, playback untouched meanwhile
      for (m = 0; m < 2; m++)
      begin
         wr(OFS_CTRL, 32'h0000_0000);
         wr(OFS_CTRL, (m == 0) ? 32'h0000_0003 : 32'h0000_0001);
         rd(OFS_STAT);
         chk("initStat", {20'h0, (m == 0) ? INIT_SHORT : INIT_LONG, 1'b1},
             rdVal);
         xfer(1'b0, 1'b1, 16'h0ABC, 16'h0ABC);
         len = (m == 0) ? 291 : 1059;
         for (n = 0; n < len; n++)
            xfer(1'b1, 1'b0, 16'h1234, 16'h0000);
         xfer(1'b1, 1'b0, 16'h1234, 16'h1234);
      end
      // reproduction, recording, loop-back with all stages off
      wr(OFS_CTRL, 32'h0000_0029);
      xfer(1'b0, 1'b1, SMP, SMP);
      wr(OFS_CTRL, 32'h0000_0035);
      xfer(1'b1, 1'b0, SMP, SMP);
      wr(OFS_CTRL, 32'h0000_003D);
      xfer(1'b1, 1'b1, SMP, SMP);
      rd(OFS_CTRL);
      chk("ctrl", 32'h0000_003D, rdVal);
      // coefficients written only while every stage is off
      wr(OFS_CTRL, 32'h0000_0029);
      wr(OFS_HPCOEF, HALFCOEF);
      wr(OFS_LPCOEF, HALFCOEF);
      rd(OFS_HPCOEF);
      chk("hpCoef", HALFCOEF, rdVal);
      run3(32'h0000_0069, HALF, 16'h0000, 16'h0000);
      run3(32'h0000_00A9, HALF, 16'h0000, 16'h0000);
      run3(32'h0000_00E9, QTR, NQTR, 16'h0000);
      run3(32'h0000_0129, HALF, SMP, SMP);
      // each band alone: y = x + 0.5 (x - x two samples back)
      for (n = 0; n < 5; n++)
      begin
         wr(OFS_CTRL, 32'h0000_0029);
         wr(OFS_EQBASE + 8'(8 * n), HALFCOEF);
         wr(OFS_EQBASE + 8'(8 * n + 4), 32'h0000_0000);
         rd(OFS_EQBASE + 8'(8 * n));
         chk("eqAB", HALFCOEF, rdVal);
         run3(32'h29 | (32'h1 << (BIT_EQEN + n)), ONEH, ONEH, SMP);
      end
      rd(OFS_CTRL);
      chk("ctrl", 32'h0000_2029, rdVal);
      tally_and_finish();
   end

endmodule
